// ### src/sew_pkg.sv
// constants and types shared by the serial eeprom write-control block
// assumes a 25 MHz system clock and a host that drives the serial link
package sew_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int WRITE_TIME_US = 5000;
  localparam int REF_CLK_KHZ = 25000;
  // longest time, so rounded down
  localparam int WRITE_CYC = WRITE_TIME_US * REF_CLK_KHZ / 1000;
  localparam int CYC_W = 17;

  // ***********************************************************
  // instruction low bits, upper nibble must be zero, bit 3 ignored
  // ***********************************************************
  localparam logic [2:0] OPC_READ = 3'h3;
  localparam logic [2:0] OPC_WRITE = 3'h2;
  localparam logic [2:0] OPC_CLR_LATCH = 3'h4;
  localparam logic [2:0] OPC_SET_LATCH = 3'h6;
  localparam logic [2:0] OPC_STAT_RD = 3'h5;
  localparam logic [2:0] OPC_STAT_WR = 3'h1;

  // ***********************************************************
  // protection_status layout and reset values
  // ***********************************************************
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam logic [1:0] GUARD_RST = 2'h0;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QTR = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [6:0] QTR_BASE = 7'h60;
  localparam logic [6:0] HALF_BASE = 7'h40;
  localparam int MEM_BYTES = 128;
  localparam int PAGE_BYTES = 16;

  typedef enum logic [2:0] {
    F_INSTR = 3'h0,
    F_ADDR = 3'h1,
    F_DATA = 3'h2,
    F_STAT = 3'h3,
    F_SKIP = 3'h4
  } sew_frame_t;

endpackage

// ### src/sew_sync.sv
// two-flop level synchroniser, one per bit
// assumes each bit is a level held long enough for the target clock
`timescale 1ns/1ps
module sew_sync #(
  parameter int W = 1
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ### src/sew_link.sv
// serial-clock side of the block: shifts bytes in, status out
// assumes sck only toggles while cs_n is low; cs_n high restarts the frame
`timescale 1ns/1ps
module sew_link (
  // link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  // reset for the handoff toggles
  input wire logic rst,
  // status bits, already synchronised to sck
  input wire logic [7:0] stat,
  // byte handoff
  output logic byte_tgl,
  output logic start_tgl,
  output logic [7:0] hold_a,
  output logic [7:0] hold_b,
  // serial out
  output logic so,
  output logic so_drive
);

  logic [2:0] bit_cnt_r;
  logic [6:0] shreg_r;
  logic first_r;
  logic stat_rd_r;
  logic [7:0] out_r;

  wire [7:0] byte_in = {shreg_r, si};
  wire last_bit = bit_cnt_r == 3'h7;
  wire is_stat_rd = byte_in[7:4] == 4'h0 && byte_in[2:0] == sew_pkg::OPC_STAT_RD;

  // ***********************************************************
  // frame state, cleared while deselected
  // ***********************************************************
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= 3'h0;
      first_r <= 1'b1;
      stat_rd_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (last_bit) begin
        first_r <= 1'b0;
      end
      if (last_bit && first_r && is_stat_rd) begin
        stat_rd_r <= 1'b1; // RULE12 RULE8
      end
    end
  end

  always_ff @(posedge sck) begin
    shreg_r <= byte_in[6:0]; // RULE19
  end

  // ***********************************************************
  // handoff: two holding bytes so each stays put for two bytes
  // ***********************************************************
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      byte_tgl <= 1'b0;
      start_tgl <= 1'b0;
      hold_a <= 8'h00;
      hold_b <= 8'h00;
    end else begin
      if (bit_cnt_r == 3'h0) begin
        start_tgl <= ~start_tgl;
      end
      if (last_bit) begin
        byte_tgl <= ~byte_tgl;
        if (byte_tgl) begin
          hold_a <= byte_in;
        end else begin
          hold_b <= byte_in;
        end
      end
    end
  end

  // ***********************************************************
  // status out, repeated every byte while selected
  // ***********************************************************
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_r <= 8'h00;
    end else if (stat_rd_r && bit_cnt_r == 3'h0) begin
      out_r <= stat; // RULE8
    end else begin
      out_r <= {out_r[6:0], 1'b0}; // RULE19
    end
  end

  assign so = out_r[7];
  assign so_drive = stat_rd_r;

endmodule

// ### src/sew_top.sv
// write control of a 128-byte serial eeprom behind a four-wire link
// assumes the host leaves two REF_CLK periods between edges of CS_N and SCK
//
// What this block does
// RULE1 - host sets write latch before any write
// RULE2 - latch set only on deselect after eight bits
// RULE3 - write frame: instruction, address, data bytes
// RULE4 - up to 16 data bytes, one page
// RULE5 - address low nibble wraps inside page
// RULE6 - write starts only on byte-aligned deselect
// RULE7 - array reads ignored while write busy
// RULE8 - status readable at any time
// RULE9 - latch clears when write cycle completes
// RULE10 - decode read x011, write x010
// RULE11 - decode latch set x110, clear x100
// RULE12 - decode status read x101, write x001
// RULE13 - latch clears on power-up, commands, protect pin
// RULE14 - status: busy, latch, two guard bits
// RULE15 - busy flag high during internal write
// RULE16 - latch flag follows latch despite guards
// RULE17 - guard bits written only by status write
// RULE18 - host polls busy flag for completion
// RULE19 - bits MSB first, sampled on rising clock
// RULE20 - self-timed write lasts 5 ms
// RULE21 - guard codes protect none, quarter, half, all
// RULE22 - protect pin low blocks all writes; a write already running when the pin drops still completes and commits
// RULE23 - address bit 7 ignored
`timescale 1ns/1ps
module sew_top #(
  parameter int WRITE_CYCLES = sew_pkg::WRITE_CYC
) (
  // system
  input wire logic REF_CLK,
  input wire logic RST,
  // serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE_N,
  // array observation
  input wire logic [6:0] PEEK_ADDR,
  output logic [7:0] PEEK_DATA
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  logic byte_tgl;
  logic start_tgl;
  logic [7:0] hold_a;
  logic [7:0] hold_b;
  logic so_drive;
  logic [3:0] pin_s;
  logic [2:0] prev_r;
  logic [3:0] stat_sck;
  sew_pkg::sew_frame_t st_r;
  sew_pkg::sew_frame_t st_nxt;
  logic [2:0] cmd_r;
  logic cmd_ok_r;
  logic [1:0] nbytes_r;
  logic in_byte_r;
  logic [2:0] page_r;
  logic [3:0] addr_lo_r;
  logic [15:0] vmask_r;
  logic [7:0] buf_r [sew_pkg::PAGE_BYTES];
  logic [1:0] stat_new_r;
  logic busy_r;
  logic kind_stat_r;
  logic [sew_pkg::CYC_W-1:0] cnt_r;
  logic latch_r;
  logic latch_nxt;
  logic [1:0] guard_r;
  logic [7:0] mem_r [sew_pkg::MEM_BYTES];
  logic [sew_pkg::MEM_BYTES-1:0] commit;
  logic [sew_pkg::CYC_W-1:0] blen_r;

  function automatic logic guarded(input logic [1:0] g, input logic [6:0] a);
    case (g)
      sew_pkg::GUARD_NONE: guarded = 1'b0;
      sew_pkg::GUARD_QTR: guarded = a >= sew_pkg::QTR_BASE;
      sew_pkg::GUARD_HALF: guarded = a >= sew_pkg::HALF_BASE;
      default: guarded = 1'b1;
    endcase
  endfunction

  // ***********************************************************
  // link side and crossings
  // ***********************************************************
  sew_link u_link (
    .sck(SCK),
    .cs_n(CS_N),
    .si(SI),
    .rst(RST),
    .stat({4'h0, stat_sck}),
    .byte_tgl(byte_tgl),
    .start_tgl(start_tgl),
    .hold_a(hold_a),
    .hold_b(hold_b),
    .so(SO),
    .so_drive(so_drive)
  );

  assign SO_OE_N = ~so_drive;

  sew_sync #(.W(4)) u_pin_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({WP_N, CS_N, start_tgl, byte_tgl}),
    .q(pin_s)
  );

  // sck stops between frames, so no reset is possible here; eight
  // instruction edges flush it before the status is shifted out
  sew_sync #(.W(4)) u_stat_sync (
    .clk(SCK),
    .rst(1'b0),
    .d({guard_r, latch_r, busy_r}), // RULE14
    .q(stat_sck)
  );

  // ***********************************************************
  // event decode
  // ***********************************************************
  wire byte_evt = pin_s[0] ^ prev_r[0];
  wire start_evt = pin_s[1] ^ prev_r[1];
  wire cs_hi = pin_s[2];
  wire cs_rise = pin_s[2] & ~prev_r[2];
  wire wp_ok = pin_s[3];
  wire [7:0] rx_byte = pin_s[0] ? hold_b : hold_a;
  wire instr_ok = rx_byte[7:4] == 4'h0;
  wire instr_wr = instr_ok && rx_byte[2:0] == sew_pkg::OPC_WRITE && !busy_r; // RULE10 RULE7
  wire instr_ws = instr_ok && rx_byte[2:0] == sew_pkg::OPC_STAT_WR && !busy_r; // RULE12
  wire data_take = byte_evt && !cs_hi && st_r == sew_pkg::F_DATA;
  wire instr_take = byte_evt && !cs_hi && st_r == sew_pkg::F_INSTR;

  // ***********************************************************
  // deselect decisions
  // ***********************************************************
  // a byte still half shifted in voids whatever the frame asked for
  wire frame_clean = cs_rise && cmd_ok_r && !in_byte_r; // RULE6 RULE2
  wire set_go = frame_clean && cmd_r == sew_pkg::OPC_SET_LATCH && nbytes_r == 2'h1; // RULE11
  wire clr_go = frame_clean && cmd_r == sew_pkg::OPC_CLR_LATCH && nbytes_r == 2'h1; // RULE11
  wire may_write = latch_r && wp_ok && !busy_r; // RULE1 RULE22
  wire arr_go = frame_clean && cmd_r == sew_pkg::OPC_WRITE && nbytes_r == 2'h3 && may_write;
  wire stat_go = frame_clean && cmd_r == sew_pkg::OPC_STAT_WR && nbytes_r >= 2'h2 && may_write;
  wire done = busy_r && cnt_r == '0;

  // ***********************************************************
  // frame parser
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    if (cs_hi) begin
      st_nxt = sew_pkg::F_INSTR;
    end else if (byte_evt) begin
      case (st_r)
        sew_pkg::F_INSTR: begin
          if (instr_wr) begin
            st_nxt = sew_pkg::F_ADDR; // RULE3
          end else if (instr_ws) begin
            st_nxt = sew_pkg::F_STAT;
          end else begin
            st_nxt = sew_pkg::F_SKIP; // RULE7
          end
        end
        sew_pkg::F_ADDR: st_nxt = sew_pkg::F_DATA; // RULE3
        sew_pkg::F_DATA: st_nxt = sew_pkg::F_DATA;
        sew_pkg::F_STAT: st_nxt = sew_pkg::F_STAT;
        default: st_nxt = sew_pkg::F_SKIP;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_r <= sew_pkg::F_INSTR;
      prev_r <= 3'h0;
      nbytes_r <= 2'h0;
      in_byte_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      prev_r <= pin_s[2:0];
      if (cs_hi) begin
        nbytes_r <= 2'h0;
        in_byte_r <= 1'b0;
      end else begin
        if (byte_evt && nbytes_r != 2'h3) begin
          nbytes_r <= nbytes_r + 2'h1;
        end
        in_byte_r <= start_evt | (in_byte_r & ~byte_evt);
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cmd_r <= 3'h0;
      cmd_ok_r <= 1'b0;
      page_r <= 3'h0;
      addr_lo_r <= 4'h0;
      vmask_r <= 16'h0000;
      stat_new_r <= 2'h0;
    end else begin
      if (instr_take) begin
        cmd_r <= rx_byte[2:0];
        cmd_ok_r <= instr_ok;
        if (instr_wr) begin
          vmask_r <= 16'h0000;
        end
      end
      if (byte_evt && !cs_hi && st_r == sew_pkg::F_ADDR) begin
        page_r <= rx_byte[6:4]; // RULE23
        addr_lo_r <= rx_byte[3:0];
      end
      if (data_take) begin
        addr_lo_r <= addr_lo_r + 4'h1; // RULE5 RULE4
        vmask_r[addr_lo_r] <= 1'b1;
      end
      if (byte_evt && !cs_hi && st_r == sew_pkg::F_STAT) begin
        stat_new_r <= rx_byte[sew_pkg::ST_GUARD_HI:sew_pkg::ST_GUARD_LO];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (data_take) begin
      buf_r[addr_lo_r] <= rx_byte; // RULE4
    end
  end

  // ***********************************************************
  // self-timed write cycle
  // ***********************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      busy_r <= 1'b0;
      kind_stat_r <= 1'b0;
      cnt_r <= '0;
    end else if (arr_go || stat_go) begin
      busy_r <= 1'b1; // RULE15 RULE6
      kind_stat_r <= stat_go;
      cnt_r <= sew_pkg::CYC_W'(WRITE_CYCLES - 1); // RULE20
    end else if (done) begin
      busy_r <= 1'b0; // RULE15
    end else if (busy_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // ***********************************************************
  // write latch and guard bits
  // ***********************************************************
  always_comb begin
    latch_nxt = latch_r;
    if (!wp_ok) begin
      latch_nxt = 1'b0; // RULE13 RULE22
    end else if (set_go) begin
      latch_nxt = 1'b1; // RULE16
    end else if (done) begin
      latch_nxt = 1'b0; // RULE9
    end else if (clr_go) begin
      latch_nxt = 1'b0; // RULE16
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      latch_r <= 1'b0; // RULE13
      guard_r <= sew_pkg::GUARD_RST;
    end else begin
      latch_r <= latch_nxt;
      if (done && kind_stat_r) begin
        guard_r <= stat_new_r; // RULE17
      end
    end
  end

  // ***********************************************************
  // array commit at the end of the cycle
  // ***********************************************************
  for (genvar j = 0; j < sew_pkg::MEM_BYTES; j++) begin : g_commit
    localparam logic [6:0] ADR = 7'(j);
    assign commit[j] = done && !kind_stat_r && page_r == ADR[6:4] && vmask_r[ADR[3:0]]
      && !guarded(guard_r, ADR); // RULE21
  end

  always_ff @(posedge REF_CLK) begin
    for (int k = 0; k < sew_pkg::MEM_BYTES; k++) begin
      if (commit[k]) begin
        mem_r[k] <= buf_r[k % sew_pkg::PAGE_BYTES];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PEEK_DATA <= 8'h00;
    end else begin
      PEEK_DATA <= mem_r[PEEK_ADDR];
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      blen_r <= '0;
    end else begin
      blen_r <= busy_r ? blen_r + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_clean_set;
    set_go && wp_ok;
  endsequence

  sequence s_write_start;
    arr_go ##1 (busy_r && !kind_stat_r);
  endsequence

  sequence s_stat_commit;
    done && kind_stat_r;
  endsequence

  AST_LATCH_SET: assert property (s_clean_set |=> latch_r) // RULE2
    else $error("latch not set after clean set frame");
  AST_WP_CLEARS: assert property (!wp_ok |=> !latch_r) // RULE13
    else $error("latch survived protect pin low");
  AST_PART_BYTE: assert property (cs_rise && in_byte_r && !busy_r |=> !busy_r) // RULE6
    else $error("write started on a partial byte");
  AST_WRITE_START: assert property (arr_go |-> s_write_start) // RULE15
    else $error("array write did not raise busy");
  AST_WRITE_GATED: assert property ($rose(busy_r) |-> $past(latch_r) && $past(wp_ok)) // RULE22
    else $error("write started without latch or with pin low");
  AST_WRITE_LEN: assert property ($fell(busy_r) |-> $past(blen_r) == WRITE_CYCLES - 1) // RULE20
    else $error("write cycle length wrong");
  AST_DONE_CLEARS: assert property (done && !set_go |=> !latch_r && !busy_r) // RULE9
    else $error("latch or busy left set after write");
  AST_PAGE_WRAP: assert property (data_take && addr_lo_r == 4'hf |=> addr_lo_r == 4'h0) // RULE5
    else $error("page address did not wrap");
  AST_BUSY_NO_WRITE: assert property (busy_r && instr_take |=> st_r == sew_pkg::F_SKIP) // RULE7
    else $error("instruction accepted during busy");
  AST_GUARD_LOAD: assert property (s_stat_commit |=> guard_r == $past(stat_new_r)) // RULE17
    else $error("guard bits not loaded");
  AST_CLR_CMD: assert property (clr_go |=> !latch_r) // RULE11
    else $error("clear latch command ignored");

endmodule

// ### tb/sew_host.sv
// host-side model of the four-wire link: frames, bytes and partial bytes
// assumes the caller keeps one frame at a time; sck idles low outside frames
`timescale 1ns/1ps
module sew_host (
  // link pins
  output logic sck,
  output logic cs_n,
  output logic si,
  // serial return
  input wire logic so,
  input wire logic so_oe_n
);
  logic last_si;
  logic oe_seen;

  // brief low first, so the link frame state sees a real deselect edge
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b1;
    last_si = 1'b0;
    oe_seen = 1'b0;
    #1;
    cs_n = 1'b1;
  end

  // ***********************************************************
  // frame steps
  // ***********************************************************
  // select gap well above two REF_CLK periods
  task automatic open_frame();
    cs_n = 1'b0;
    oe_seen = 1'b0;
    #100;
  endtask

  // n bits of b from the top, so sampled at each rising edge
  task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = b[i];
      last_si = b[i];
      #7.5;
      sck = 1'b1;
      r[i] = so;
      if (so_oe_n === 1'b0) begin
        oe_seen = 1'b1;
      end
      #7.5;
      sck = 1'b0;
    end
  endtask

  // deselect ends the frame; only a whole last byte makes it count
  task automatic close_frame();
    #100;
    cs_n = 1'b1;
    // released line must not look like the last bit
    si = ~last_si;
    #200;
  endtask
endmodule

// ### tb/testbench.sv
// self-checking bench for the serial eeprom write-control block
// assumes the host model drives the link; array contents seen through the peek port
`timescale 1ns/1ps
module testbench;
  // short write cycle keeps the run small
  localparam int WC = 60;
  logic REF_CLK;
  logic RST;
  logic WP_N;
  logic [6:0] PEEK_ADDR;
  logic [7:0] PEEK_DATA;
  wire logic sck;
  wire logic cs_n;
  wire logic si;
  wire logic so;
  wire logic so_oe_n;
  int bad_count;
  int n_checks;
  logic [7:0] exp_mem [0:127];
  logic [7:0] s;
  logic [7:0] a;
  logic [7:0] r;
  logic prot;

  sew_top #(.WRITE_CYCLES(WC)) dut (
    .REF_CLK(REF_CLK), .RST(RST), .SCK(sck), .CS_N(cs_n), .SI(si), .WP_N(WP_N),
    .SO(so), .SO_OE_N(so_oe_n), .PEEK_ADDR(PEEK_ADDR), .PEEK_DATA(PEEK_DATA)
  );
  sew_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));

  initial REF_CLK = 1'b0;
  always #20 REF_CLK = ~REF_CLK;

  // ***********************************************************
  // reporting
  // ***********************************************************
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ***********************************************************
  // link access
  // ***********************************************************
  // one-byte frame; nbits below 8 leaves a partial byte
  task automatic cmd(input logic [7:0] op, input int nbits);
    logic [7:0] rr;
    host.open_frame();
    host.shift(op, nbits, rr);
    host.close_frame();
  endtask

  task automatic rd_stat(output logic [7:0] st);
    logic [7:0] rr;
    host.open_frame();
    host.shift(8'h05, 8, rr);
    host.shift(8'hff, 8, st);
    host.close_frame();
  endtask

  // instruction, address (array writes only), n bytes d0+i, then tail stray bits
  task automatic wr(input logic [7:0] op, input logic [7:0] ad, input int n,
                    input logic [7:0] d0, input int tail);
    logic [7:0] rr;
    host.open_frame();
    host.shift(op, 8, rr);
    if (op[2:0] == 3'h2) begin
      host.shift(ad, 8, rr);
    end
    for (int i = 0; i < n; i++) begin
      host.shift(d0 + 8'(i), 8, rr);
    end
    if (tail > 0) begin
      host.shift(8'h3c, tail, rr);
    end
    host.close_frame();
  endtask

  // bounded busy poll; running out ends the run
  task automatic wait_idle();
    logic [7:0] st;
    for (int k = 0; k < 20; k++) begin
      rd_stat(st);
      if (st[0] === 1'b0) begin
        return;
      end
    end
    bad_count++;
    $display("Error at %0t: write never finished", $time);
    close_out();
  endtask

  task automatic peek(input logic [6:0] ad, input logic [7:0] exp);
    @(negedge REF_CLK);
    PEEK_ADDR = ad;
    @(negedge REF_CLK);
    @(negedge REF_CLK);
    chk8(PEEK_DATA, exp);
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  initial begin
    // low then high before the first clock edge: link toggles need a real reset edge
    RST = 1'b0;
    WP_N = 1'b1;
    #1;
    RST = 1'b1;
    PEEK_ADDR = 7'h00;
    bad_count = 0;
    n_checks = 0;
    repeat (4) @(negedge REF_CLK);
    RST = 1'b0;
    repeat (4) @(negedge REF_CLK);
    rd_stat(s);
    chk8(s, 8'h00);
    // latch commands with bit 3 clear and set
    for (int i = 0; i < 2; i++) begin
      a = (i == 1) ? 8'h08 : 8'h00;
      cmd(8'h06 | a, 8);
      rd_stat(s);
      chk8(s, 8'h02);
      cmd(8'h04 | a, 8);
      rd_stat(s);
      chk8(s, 8'h00);
    end
    cmd(8'h16, 8);
    rd_stat(s);
    chk8(s, 8'h00);
    cmd(8'h06, 7);
    rd_stat(s);
    chk8(s, 8'h00);
    // write straight after the latch command, no deselect between
    host.open_frame();
    host.shift(8'h06, 8, r);
    host.shift(8'h02, 8, r);
    host.shift(8'h05, 8, r);
    host.shift(8'h99, 8, r);
    host.close_frame();
    rd_stat(s);
    chk8(s, 8'h00);
    // every guard code against a low, middle and top address
    for (int g = 0; g < 4; g++) begin
      cmd(8'h06, 8);
      wr((g % 2 == 1) ? 8'h09 : 8'h01, 8'h00, 1, {4'h0, 2'(g), 2'h0}, 0);
      wait_idle();
      rd_stat(s);
      chk8(s, {4'h0, 2'(g), 2'h0});
      for (int j = 0; j < 3; j++) begin
        a = (j == 0) ? 8'h05 : ((j == 1) ? 8'h45 : 8'h65);
        cmd(8'h06, 8);
        rd_stat(s);
        chk8(s, {4'h0, 2'(g), 2'h2});
        wr((j == 1) ? 8'h0a : 8'h02, a, 1, {4'(g), 4'(j)}, 0);
        wait_idle();
        prot = (g == 3) || (g == 2 && a >= 8'h40) || (g == 1 && a >= 8'h60);
        if (!prot) begin
          exp_mem[a[6:0]] = {4'(g), 4'(j)};
        end
        peek(a[6:0], exp_mem[a[6:0]]);
      end
    end
    cmd(8'h06, 8);
    wr(8'h01, 8'h00, 1, 8'h00, 0);
    wait_idle();
    // byte write with address bit 7 set, array read while busy
    cmd(8'h06, 8);
    wr(8'h02, 8'h85, 1, 8'ha5, 0);
    host.open_frame();
    host.shift(8'h03, 8, r);
    host.shift(8'h05, 8, r);
    host.shift(8'hff, 8, r);
    host.close_frame();
    chk8({7'h00, host.oe_seen}, 8'h00);
    rd_stat(s);
    chk8(s, 8'h03);
    wait_idle();
    rd_stat(s);
    chk8(s, 8'h00);
    exp_mem[7'h05] = 8'ha5;
    peek(7'h05, 8'ha5);
    // eighteen bytes from 2c wrap inside the page
    cmd(8'h06, 8);
    wr(8'h02, 8'h2c, 18, 8'h40, 0);
    wait_idle();
    for (int i = 0; i < 18; i++) begin
      exp_mem[{3'h2, 4'(4'hc + 4'(i))}] = 8'h40 + 8'(i);
    end
    for (int i = 0; i < 16; i++) begin
      peek(7'h20 + 7'(i), exp_mem[7'h20 + 7'(i)]);
    end
    // deselect three bits into a data byte aborts the write
    cmd(8'h06, 8);
    wr(8'h02, 8'h05, 1, 8'h5a, 3);
    rd_stat(s);
    chk8(s, 8'h02);
    peek(7'h05, 8'ha5);
    cmd(8'h04, 8);
    // write with the latch clear does nothing
    wr(8'h02, 8'h05, 1, 8'h11, 0);
    rd_stat(s);
    chk8(s, 8'h00);
    peek(7'h05, 8'ha5);
    // protect pin dropped while a write runs
    cmd(8'h06, 8);
    wr(8'h02, 8'h05, 1, 8'hc3, 0);
    @(negedge REF_CLK);
    WP_N = 1'b0;
    wait_idle();
    peek(7'h05, 8'hc3);
    cmd(8'h06, 8);
    rd_stat(s);
    chk8(s, 8'h00);
    @(negedge REF_CLK);
    WP_N = 1'b1;
    close_out();
  end
endmodule
